// ---- core/ebc_cycle_ctrl.v ----
// External bus cycle controller: regular, fast and CPU space cycles
`timescale 1ns/1ns
`include "ebc_regs.vh"
// Summary of operation
// - Drive address and size lines to open every external transfer.
// - Acknowledged regular cycles last three clocks minimum; wait states added unbounded.
// - Bus error together with halt acts as bus error alone.
// - Optional bus monitor raises bus error after selectable timeout, max 64.
// - Reads fetch two bytes for word or long, one for byte.
// - Writes drive two bytes for word or long, one for byte.
// - Fast chip-select cycles finish in two clocks with internal acknowledge.
// - External acknowledge always honoured, whatever the internal option.
// - Acknowledge held low gives three-clock cycles, except fast ones.
// - Only acknowledge code 1110 selects fast termination.
// - Fast reads assert data strobe, fast writes do not.
// - Function code picks space; 7 is CPU space; valid with address strobe.
// - CPU space cycles put type on address 19..16: 0, 3, F.
// - Breakpoint request sampled with read data and tagged onto it.
// - Tagged breakpoint acknowledged after the owning instruction completes.
// - Breakpoint acknowledge is word read at CPU space 00001e.
// - Size lines carry bytes remaining; lowest address bit is offset.
module ebc_cycle_ctrl #(
    parameter ADDR_W = 24
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Core request side
    input wire req,
    input wire req_write,
    input wire [1:0] req_size,
    input wire [ADDR_W-1:0] req_addr,
    input wire [2:0] req_fc,
    input wire [31:0] req_wdata,
    input wire req_prefetch,
    input wire instr_done,
    // Chip-select match and option
    input wire cs_match,
    input wire [3:0] cs_ack_code,
    // Configuration
    input wire monitor_enable,
    input wire [1:0] monitor_timeout_sel,
    // Core answer side
    output reg done_ff,
    output reg bus_error_n_ff,
    output reg [31:0] rdata_ff,
    output reg breakpoint_req_n_tag_ff,
    output reg breakpoint_req_n_exception_ff,
    output reg busy_ff,
    // External bus pins
    output reg [ADDR_W-1:0] addr_ff,
    output reg [1:0] xfer_size_ff,
    output reg [2:0] function_code_ff,
    output reg rw_ff,
    output reg addr_strobe_n_ff,
    output reg data_strobe_n_ff,
    output reg [15:0] data_out_ff,
    output reg data_oe_ff,
    input wire [15:0] data_in,
    input wire [1:0] size_ack_n,
    input wire bus_error_n,
    input wire halt_n,
    input wire breakpoint_req_n
);
    // States
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_NEXT = 2'h2;
    localparam ST_TAIL = 2'h3; // Fast read waiting out the pin synchronisers

    reg [1:0] state_ff;
    reg [1:0] clk_cnt_ff;
    reg fast_ff;
    reg is_breakpoint_req_n_ff;
    reg [2:0] left_ff;
    reg [1:0] got_ff;
    reg breakpoint_req_n_pend_ff;
    reg [1:0] ack_s1_ff, ack_s2_ff;
    reg bus_error_n_s1_ff, bus_error_n_s2_ff, halt_s1_ff, halt_s2_ff, breakpoint_req_n_s1_ff, breakpoint_req_n_s2_ff;
    reg [15:0] din_s1_ff, din_s2_ff;
    wire mon_timeout;
    wire ext_ack;
    wire bus_err;
    wire ack_ok;
    wire [2:0] nxt_left;
    wire [1:0] nxt_got;
    wire [ADDR_W-1:0] nxt_addr;
    wire fast_wait;
    wire finish;

    // Size code for the bytes still to move
    function [1:0] size_code;
        input [2:0] n;
        begin
            case (n)
                3'h1: size_code = `EBC_SIZE_BYTE;
                3'h2: size_code = `EBC_SIZE_WORD;
                3'h3: size_code = `EBC_SIZE_THREE;
                default: size_code = `EBC_SIZE_LONG;
            endcase
        end
    endfunction

    // Bytes moved this cycle from port width, offset and remaining count
    function [1:0] moved;
        input [1:0] ack_n;
        input a0;
        input [2:0] n;
        begin
            if (ack_n == 2'h2 || a0 || n == 3'h1)
                moved = 2'h1; // 8-bit port, odd offset or one byte left
            else
                moved = 2'h2;
        end
    endfunction

    // Two-flop synchronisers for all pins
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_s1_ff <= 2'h3;
            ack_s2_ff <= 2'h3;
            bus_error_n_s1_ff <= 1'b1;
            bus_error_n_s2_ff <= 1'b1;
            halt_s1_ff <= 1'b1;
            halt_s2_ff <= 1'b1;
            breakpoint_req_n_s1_ff <= 1'b1;
            breakpoint_req_n_s2_ff <= 1'b1;
            din_s1_ff <= 16'h0000;
            din_s2_ff <= 16'h0000;
        end else begin
            ack_s1_ff <= size_ack_n;
            ack_s2_ff <= ack_s1_ff;
            bus_error_n_s1_ff <= bus_error_n;
            bus_error_n_s2_ff <= bus_error_n_s1_ff;
            halt_s1_ff <= halt_n;
            halt_s2_ff <= halt_s1_ff;
            breakpoint_req_n_s1_ff <= breakpoint_req_n;
            breakpoint_req_n_s2_ff <= breakpoint_req_n_s1_ff;
            din_s1_ff <= data_in;
            din_s2_ff <= din_s1_ff;
        end
    end

    ebc_bus_monitor u_mon (
        .clk(clk),
        .rstn(rstn),
        .enable(monitor_enable),
        .timeout_sel(monitor_timeout_sel),
        .cycle_active(state_ff == ST_RUN),
        .timeout_ff(mon_timeout)
    );

    // Termination terms; halt alone never ends a cycle here
    assign ext_ack = (ack_s2_ff != 2'h3);
    assign bus_err = !bus_error_n_s2_ff || mon_timeout;
    assign ack_ok = fast_ff ? (clk_cnt_ff >= `EBC_FAST_CYC - 2'h1) || ext_ack
                            : ext_ack
                              && (clk_cnt_ff >= `EBC_REG_MIN_CYC - 2'h1);
    // A fast read ends on the pins before its data clears the two sync stages,
    // so the bytes are taken two clocks later from the synchronised copy
    assign fast_wait = fast_ff && rw_ff && !ext_ack;
    assign finish = (state_ff == ST_RUN && !bus_err && ack_ok && !fast_wait)
                    || (state_ff == ST_TAIL && clk_cnt_ff == 2'h1);
    assign nxt_got = fast_ff && !ext_ack ? moved(2'h1, addr_ff[0], left_ff)
                                         : moved(ack_s2_ff, addr_ff[0], left_ff);
    assign nxt_left = left_ff - {1'b0, nxt_got};
    assign nxt_addr = addr_ff + {{(ADDR_W-2){1'b0}}, nxt_got};

    // Main cycle sequencer
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            clk_cnt_ff <= 2'h0;
            fast_ff <= 1'b0;
            is_breakpoint_req_n_ff <= 1'b0;
            left_ff <= 3'h0;
            got_ff <= 2'h0;
            done_ff <= 1'b0;
            bus_error_n_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            breakpoint_req_n_tag_ff <= 1'b0;
            breakpoint_req_n_exception_ff <= 1'b0;
            breakpoint_req_n_pend_ff <= 1'b0;
            busy_ff <= 1'b0;
            addr_ff <= {ADDR_W{1'b0}};
            xfer_size_ff <= 2'h0;
            function_code_ff <= 3'h0;
            rw_ff <= 1'b1;
            addr_strobe_n_ff <= 1'b1;
            data_strobe_n_ff <= 1'b1;
            data_out_ff <= 16'h0000;
            data_oe_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            breakpoint_req_n_exception_ff <= 1'b0;
            // Prefetch tag is held until its instruction completes
            if (instr_done && breakpoint_req_n_pend_ff) begin
                breakpoint_req_n_pend_ff <= 1'b0;
            end
            case (state_ff)
                ST_IDLE: begin
                    if (breakpoint_req_n_pend_ff && instr_done) begin
                        // Acknowledge cycle: word read in CPU space
                        is_breakpoint_req_n_ff <= 1'b1;
                        fast_ff <= 1'b0;
                        rw_ff <= 1'b1;
                        left_ff <= 3'h2;
                        addr_ff <= `EBC_BREAKPOINT_REQ_N_ADDR | ({{(ADDR_W-4){1'b0}}, `EBC_CPU_TYPE_BREAKPOINT_REQ_N} << 16);
                        function_code_ff <= `EBC_FC_CPU_SPACE;
                        xfer_size_ff <= `EBC_SIZE_WORD;
                        state_ff <= ST_NEXT;
                        busy_ff <= 1'b1;
                    end else if (req) begin
                        is_breakpoint_req_n_ff <= 1'b0;
                        fast_ff <= cs_match && (cs_ack_code == `EBC_ACK_FAST);
                        rw_ff <= !req_write;
                        left_ff <= (req_size == `EBC_SIZE_BYTE) ? 3'h1 :
                                   (req_size == `EBC_SIZE_WORD) ? 3'h2 : 3'h4;
                        addr_ff <= req_addr;
                        function_code_ff <= req_fc;
                        xfer_size_ff <= req_size;
                        rdata_ff <= 32'h00000000;
                        breakpoint_req_n_tag_ff <= 1'b0;
                        state_ff <= ST_NEXT;
                        busy_ff <= 1'b1;
                    end
                end
                ST_NEXT: begin
                    // Start one bus cycle for the bytes still owed
                    xfer_size_ff <= size_code(left_ff);
                    addr_strobe_n_ff <= 1'b0;
                    data_strobe_n_ff <= fast_ff && !rw_ff;
                    data_oe_ff <= !rw_ff;
                    // Upper lane always carries the next byte for 8-bit ports
                    if (addr_ff[0])
                        data_out_ff <= {2{req_wdata[8*left_ff-1 -: 8]}};
                    else if (left_ff == 3'h1)
                        data_out_ff <= {2{req_wdata[7:0]}};
                    else
                        data_out_ff <= req_wdata[8*left_ff-1 -: 16];
                    clk_cnt_ff <= 2'h0;
                    state_ff <= ST_RUN;
                end
                ST_RUN: begin
                    if (clk_cnt_ff != 2'h3)
                        clk_cnt_ff <= clk_cnt_ff + 2'h1;
                    if (bus_err) begin
                        // Bus error wins even with halt; no data latched
                        addr_strobe_n_ff <= 1'b1;
                        data_strobe_n_ff <= 1'b1;
                        data_oe_ff <= 1'b0;
                        bus_error_n_ff <= 1'b1;
                        done_ff <= 1'b1;
                        busy_ff <= 1'b0;
                        breakpoint_req_n_exception_ff <= is_breakpoint_req_n_ff;
                        state_ff <= ST_IDLE;
                    end else if (ack_ok) begin
                        // Pins released now; bytes are taken in the closing step below
                        addr_strobe_n_ff <= 1'b1;
                        data_strobe_n_ff <= 1'b1;
                        data_oe_ff <= 1'b0;
                        clk_cnt_ff <= 2'h0;
                        if (fast_wait)
                            state_ff <= ST_TAIL;
                    end
                    // Otherwise a wait state, with no upper bound
                end
                ST_TAIL: begin
                    // Bus already idle; wait for read data to leave the synchroniser
                    clk_cnt_ff <= clk_cnt_ff + 2'h1;
                end
                default: state_ff <= ST_IDLE;
            endcase
            // Close one bus cycle: capture read bytes, then next cycle or done
            if (finish) begin
                // Odd offset reads the lower lane of a 16-bit port
                if (rw_ff) begin
                    if (nxt_got == 2'h2)
                        rdata_ff <= {rdata_ff[15:0], din_s2_ff};
                    else if (addr_ff[0] && ack_s2_ff != 2'h2)
                        rdata_ff <= {rdata_ff[23:0], din_s2_ff[7:0]};
                    else
                        rdata_ff <= {rdata_ff[23:0], din_s2_ff[15:8]};
                    if (!breakpoint_req_n_s2_ff && !is_breakpoint_req_n_ff) begin
                        breakpoint_req_n_tag_ff <= 1'b1;
                        breakpoint_req_n_pend_ff <= 1'b1;
                    end
                end
                addr_ff <= nxt_addr;
                left_ff <= nxt_left;
                got_ff <= nxt_got;
                if (nxt_left == 3'h0) begin
                    bus_error_n_ff <= 1'b0;
                    done_ff <= 1'b1;
                    busy_ff <= 1'b0;
                    breakpoint_req_n_exception_ff <= is_breakpoint_req_n_ff;
                    state_ff <= ST_IDLE;
                end else begin
                    state_ff <= ST_NEXT;
                end
            end
        end
    end
endmodule // ebc_cycle_ctrl

// ---- pkg/ebc_regs.vh ----
// Constants for the external bus cycle controller
`ifndef EBC_REGS_VH
`define EBC_REGS_VH
// Transfer size encodings (bytes still to move)
`define EBC_SIZE_LONG 2'h0
`define EBC_SIZE_BYTE 2'h1
`define EBC_SIZE_WORD 2'h2
`define EBC_SIZE_THREE 2'h3
// Function codes
`define EBC_FC_CPU_SPACE 3'h7
// CPU space cycle types on address bits 19..16
`define EBC_CPU_TYPE_BREAKPOINT_REQ_N 4'h0
`define EBC_CPU_TYPE_STOP 4'h3
`define EBC_CPU_TYPE_IACK 4'hf
// Breakpoint acknowledge address (low word)
`define EBC_BREAKPOINT_REQ_N_ADDR 24'h00001e
// Fast termination acknowledge code
`define EBC_ACK_FAST 4'he
// External cycle lengths in clocks: regular minimum, fast maximum
`define EBC_REG_MIN_CYC 2'h3
`define EBC_FAST_CYC 2'h2
// Bus monitor timeouts in clocks, per select code
`define EBC_BMT_0 7'h40
`define EBC_BMT_1 7'h20
`define EBC_BMT_2 7'h10
`define EBC_BMT_3 7'h08
`endif

// ---- core/ebc_bus_monitor.v ----
// Bus monitor: flags a cycle that waits too long for acknowledge
`timescale 1ns/1ns
`include "ebc_regs.vh"
module ebc_bus_monitor (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Control
    input wire enable,
    input wire [1:0] timeout_sel,
    input wire cycle_active,
    // Result
    output reg timeout_ff
);
    reg [6:0] count_ff;
    wire [6:0] limit;

    // Timeout limit per select code, longest 64 clocks
    assign limit = (timeout_sel == 2'h0) ? `EBC_BMT_0 :
                   (timeout_sel == 2'h1) ? `EBC_BMT_1 :
                   (timeout_sel == 2'h2) ? `EBC_BMT_2 : `EBC_BMT_3;

    // Count clocks of an open cycle; pulse once at the limit
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_ff <= 7'h00;
            timeout_ff <= 1'b0;
        end else if (!cycle_active || !enable) begin
            count_ff <= 7'h00;
            timeout_ff <= 1'b0;
        end else begin
            if (count_ff != 7'h7f)
                count_ff <= count_ff + 7'h01;
            timeout_ff <= (count_ff + 7'h01 == limit);
        end
    end
endmodule // ebc_bus_monitor

// ---- verification/ebc_cycle_ctrl_properties.sv ----
// Pin-level checks for the external bus cycle controller
`timescale 1ns/1ns
`include "ebc_regs.vh"
module ebc_cycle_checker #(
    parameter ADDR_W = 24
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Setup inputs
    input wire cs_match,
    input wire [3:0] cs_ack_code,
    input wire monitor_enable,
    input wire [1:0] monitor_timeout_sel,
    // Bus pins
    input wire [ADDR_W-1:0] addr_ff,
    input wire [1:0] xfer_size_ff,
    input wire [2:0] function_code_ff,
    input wire rw_ff,
    input wire addr_strobe_n_ff,
    input wire data_strobe_n_ff,
    input wire data_oe_ff,
    input wire [1:0] size_ack_n,
    input wire bus_error_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Cycle kind and quiet-bus flags
    wire fast = cs_match && (cs_ack_code == `EBC_ACK_FAST);
    wire quiet = (size_ack_n == 2'h3) && bus_error_n;
    wire on = !addr_strobe_n_ff;
    // Strobe-low length; saturates so a hung cycle cannot wrap
    reg [7:0] low_cnt_ff;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) low_cnt_ff <= 8'h00;
        else if (!on) low_cnt_ff <= 8'h00;
        else if (low_cnt_ff != 8'hff) low_cnt_ff <= low_cnt_ff + 8'h01;
    end
    sequence s_fast_start;
        $fell(addr_strobe_n_ff) && fast;
    endsequence
    sequence s_reg_start;
        $fell(addr_strobe_n_ff) && !fast;
    endsequence
    a_addr_held: assert property (on && $past(on) |-> $stable(addr_ff) && $stable(xfer_size_ff))
        else $error("address or size moved inside a cycle");
    a_fast_two: assert property (s_fast_start |-> ##[1:2] addr_strobe_n_ff)
        else $error("fast cycle too long");
    a_three_min: assert property (s_reg_start |-> on [*3])
        else $error("regular cycle under three clocks");
    a_wait_no_ack: assert property (on && !fast && !monitor_enable && low_cnt_ff > 8'h03
        && quiet && $past(quiet) && $past(quiet, 2) |=> on) else $error("cycle ended without ack");
    a_fast_wr_quiet: assert property (on && fast && !rw_ff |-> data_strobe_n_ff)
        else $error("data strobe on fast write");
    a_cpu_type: assert property (on && function_code_ff == `EBC_FC_CPU_SPACE |->
        addr_ff[19:16] inside {`EBC_CPU_TYPE_BREAKPOINT_REQ_N, `EBC_CPU_TYPE_STOP, `EBC_CPU_TYPE_IACK})
        else $error("bad cpu space type");
    a_breakpoint_req_n_addr: assert property (on && function_code_ff == `EBC_FC_CPU_SPACE
        && addr_ff[19:16] == `EBC_CPU_TYPE_BREAKPOINT_REQ_N |-> addr_ff == `EBC_BREAKPOINT_REQ_N_ADDR && rw_ff
        && xfer_size_ff == `EBC_SIZE_WORD) else $error("bad breakpoint ack cycle");
    a_bus_error_n_ends: assert property (on && $fell(bus_error_n) |-> ##[1:5] addr_strobe_n_ff)
        else $error("bus error did not end cycle");
    a_monitor_cap: assert property (monitor_enable |->
        low_cnt_ff <= (8'h40 >> monitor_timeout_sel) + 8'h06) else $error("monitor too late");
    a_oe_dir: assert property (on |-> data_oe_ff == !rw_ff)
        else $error("data drive does not match direction");
    a_fast_rd_ds: assert property (on && fast && rw_ff |-> !data_strobe_n_ff)
        else $error("no data strobe on fast read");
endmodule // ebc_cycle_checker
bind ebc_cycle_ctrl ebc_cycle_checker #(.ADDR_W(ADDR_W)) i_ebc_cycle_checker (.*);

// ---- verification/ebc_periph_model.sv ----
// Behavioural memory or peripheral on the far side of the external bus
`timescale 1ns/1ns
module ebc_periph_model (
    // Clock and bus pins from the controller
    input wire clk,
    input wire [23:0] addr_ff,
    input wire rw_ff,
    input wire addr_strobe_n_ff,
    input wire [1:0] xfer_size_ff,
    input wire [15:0] data_out_ff,
    // Answer lines
    output reg [15:0] data_in,
    output reg [1:0] size_ack_n,
    output reg bus_error_n,
    output reg halt_n,
    // Behaviour chosen by the bench
    input wire port8,
    input wire [3:0] delay,
    input wire mute,
    input wire give_bus_error_n,
    input wire give_halt
);
    reg [7:0] mem [0:255];
    reg [3:0] wait_cnt;
    wire [7:0] ev = {addr_ff[7:1], 1'b0};
    wire [7:0] od = {addr_ff[7:1], 1'b1};
    integer i;
    // Pattern fill the bench can work out for itself
    initial begin
        for (i = 0; i < 256; i = i + 1) mem[i] = i[7:0] ^ 8'h5a;
        {data_in, size_ack_n, bus_error_n, halt_n, wait_cnt} = {16'h0000, 4'hf, 4'h0};
    end
    // Answer after the set delay; idle lines pull up, stale data toggles
    always @(posedge clk) begin
        if (addr_strobe_n_ff) begin
            {size_ack_n, bus_error_n, halt_n, wait_cnt} <= {4'hf, 4'h0};
            data_in <= ~data_in;
        end else if (wait_cnt != delay) begin
            wait_cnt <= wait_cnt + 4'h1;
        end else begin
            halt_n <= !give_halt;
            if (!mute && give_bus_error_n) bus_error_n <= 1'b0;
            else if (!mute) size_ack_n <= port8 ? 2'h2 : 2'h1;
            if (rw_ff && port8) data_in <= {mem[addr_ff[7:0]], ~data_in[7:0]};
            else if (rw_ff) data_in <= {mem[ev], mem[od]};
            else if (port8 || (xfer_size_ff == 2'h1 && !addr_ff[0])) mem[addr_ff[7:0]] <= data_out_ff[15:8];
            else if (xfer_size_ff == 2'h1) mem[addr_ff[7:0]] <= data_out_ff[7:0];
            else {mem[ev], mem[od]} <= data_out_ff;
        end
    end
endmodule // ebc_periph_model

// ---- verification/test_external_bus_cycle_control.sv ----
// Self-checking bench for the external bus cycle controller
`timescale 1ns/1ns
`include "ebc_regs.vh"
module test_external_bus_cycle_control;
    logic clk, rstn, req, req_write, req_prefetch, instr_done, cs_match, monitor_enable;
    logic breakpoint_req_n, port8, mute, give_bus_error_n, give_halt;
    logic [1:0] req_size, monitor_timeout_sel;
    logic [2:0] req_fc;
    logic [3:0] cs_ack_code, delay;
    logic [23:0] req_addr, seen_addr;
    logic [31:0] req_wdata;
    wire done_ff, bus_error_n_ff, breakpoint_req_n_tag_ff, breakpoint_req_n_exception_ff, busy_ff, rw_ff;
    wire addr_strobe_n_ff, data_strobe_n_ff, data_oe_ff, bus_error_n, halt_n;
    wire [1:0] xfer_size_ff, size_ack_n;
    wire [2:0] function_code_ff;
    wire [15:0] data_out_ff, data_in;
    wire [23:0] addr_ff;
    wire [31:0] rdata_ff;
    int err_total = 0, total_checks = 0, n, k, lo;
    ebc_cycle_ctrl i_ebc_cycle_ctrl (.*);
    ebc_periph_model i_ebc_periph_model (.*);
    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask
    // One request, then a bounded wait for the done pulse
    task automatic xfer(input logic w, input logic [1:0] sz, input logic [23:0] a,
                        input logic [31:0] wd);
        {req_write, req_size, req_addr, req_wdata, req} = {w, sz, a, wd, 1'b1};
        n = 0;
        lo = 0;
        @(negedge clk);
        req = 1'b0;
        while (done_ff !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
            // Strobe-low clocks, seen settled at the falling edge
            if (addr_strobe_n_ff === 1'b0) lo++;
        end
        chk("done seen", 1, n < 300);
        @(negedge clk);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang cutter; the tests need only a few hundred cycles
    initial begin
        #80000;
        err_total++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {rstn, req, req_write, req_prefetch, instr_done, cs_match, monitor_enable} = '0;
        {port8, mute, give_bus_error_n, give_halt, req_size, monitor_timeout_sel, cs_ack_code, delay} = '0;
        {req_addr, seen_addr, req_wdata} = '0;
        req_fc = 3'h5;
        breakpoint_req_n = 1'b1;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        xfer(1, `EBC_SIZE_WORD, 24'h000010, 32'h0000c3a5);
        xfer(0, `EBC_SIZE_WORD, 24'h000010, 0);
        chk("word 16", 32'h0000c3a5, rdata_ff);
        chk("three clocks", 1, lo >= 3);
        port8 = 1'b1;
        xfer(0, `EBC_SIZE_WORD, 24'h000010, 0);
        chk("word 8", 32'h0000c3a5, rdata_ff);
        xfer(1, `EBC_SIZE_BYTE, 24'h000021, 32'h00000077);
        port8 = 1'b0;
        xfer(0, `EBC_SIZE_BYTE, 24'h000021, 0);
        chk("odd byte", 32'h00000077, rdata_ff);
        xfer(0, `EBC_SIZE_LONG, 24'h000040, 0);
        chk("long", 32'h1a1b1819, rdata_ff);
        delay = 4'h6;
        xfer(0, `EBC_SIZE_WORD, 24'h000010, 0);
        chk("wait span", 1, n > 6);
        delay = 4'h0;
        $display("test done: regular cycles");
        // Silent bus: the monitor ends regular cycles, the internal acknowledge ends fast ones
        mute = 1'b1;
        monitor_enable = 1'b1;
        for (k = 0; k < 4; k++) begin
            monitor_timeout_sel = k[1:0];
            xfer(0, `EBC_SIZE_WORD, 24'h000010, 0);
            chk("timeout bus_error_n", 1, bus_error_n_ff);
            chk("timeout span", 1, n >= (64 >> k) - 2 && n <= (64 >> k) + 8);
        end
        cs_match = 1'b1; // A single select matches, so no shared settings
        cs_ack_code = 4'hd;
        xfer(0, `EBC_SIZE_WORD, 24'h000010, 0);
        chk("not fast", 1, bus_error_n_ff);
        cs_ack_code = `EBC_ACK_FAST;
        xfer(0, `EBC_SIZE_WORD, 24'h000010, 0);
        chk("fast data", 32'h0000c3a5, rdata_ff);
        chk("fast span", 1, lo == 2 && bus_error_n_ff === 1'b0);
        xfer(1, `EBC_SIZE_BYTE, 24'h000031, 32'h0000009c);
        {cs_match, mute, monitor_enable} = 3'h0;
        xfer(0, `EBC_SIZE_BYTE, 24'h000031, 0);
        chk("fast write", 32'h0000009c, rdata_ff);
        $display("test done: monitor and fast cycles");
        // Error, halt alone, error with halt
        for (k = 1; k < 4; k++) begin
            {give_halt, give_bus_error_n} = k[1:0];
            xfer(0, `EBC_SIZE_WORD, 24'h000010, 0);
            chk("error end", k[0], bus_error_n_ff);
        end
        {give_halt, give_bus_error_n} = 2'h0;
        $display("test done: bus errors");
        breakpoint_req_n = 1'b0;
        xfer(0, `EBC_SIZE_WORD, 24'h000010, 0);
        chk("breakpoint_req_n tag", 1, breakpoint_req_n_tag_ff);
        instr_done = 1'b1;
        @(negedge clk);
        instr_done = 1'b0;
        for (k = 0; k < 100 && breakpoint_req_n_exception_ff !== 1'b1; k++) begin
            if (addr_strobe_n_ff === 1'b0) begin
                seen_addr = addr_ff;
                breakpoint_req_n = 1'b1; // Held until the ack cycle shows
            end
            @(negedge clk);
        end
        chk("breakpoint_req_n addr", `EBC_BREAKPOINT_REQ_N_ADDR, seen_addr);
        chk("breakpoint_req_n done", 1, breakpoint_req_n_exception_ff);
        $display("test done: breakpoint");
        tally_and_finish();
    end
endmodule // test_external_bus_cycle_control
